/* src/rio_pkg.sv */
// constants and types for the receiver pin control block
// What this block does
// (R1) The pending flag goes active once the buffered byte count is nonzero and reaches the threshold, polarity set by config.
// (R2) The pending flag can be steered onto the serial transmit pin or onto the event pin when that is no input.
// (R3) After reset the pending flag stays inactive until configuration enables it.
// (R4) A low level on the reset input resets the block except the backup RAM, and that pin is never driven.
// (R5) A hardware reset clears the time counter but leaves the backup RAM contents alone.
// (R6) The event input can wake the receiver in power save and feed aiding, and starts disabled.
// (R7) With power control on, the event level overrides the power save on and off cycle.
// (R8) Outside power save the event input can force the receiver off.
// (R9) With time aiding on, an event edge realigns the internal time.
// (R10) The far party gives frequency aiding of at most 500 kHz with each phase at least 50 ns.
// (R11) The select strap picks UART and two-wire when open and SPI when low, never both.
// (R12) The time strobe is configurable and defaults to one pulse every second.
// (R13) The far party never pulls the service boot pin low during reset or start-up.
// (R14) In power save the amplifier enable is high in the active phase and low when inactive.
// (R15) The select strap pin reads high when left open, thanks to a pull-up.
// (R16) With the strap low the two-wire data and clock pins carry SPI select and clock.
// (R17) The pending flag drops again once the byte count falls below the threshold.
package rio_pkg;
  localparam int unsigned CLK_HZ        = 250_000_000;
  localparam int unsigned STROBE_PER_S  = 1;
  localparam int unsigned STROBE_CYC    = CLK_HZ / STROBE_PER_S;
  localparam logic [31:0] STROBE_CYC_RST = 32'(STROBE_CYC);
  localparam logic [31:0] STROBE_WID_RST = 32'h017d7840;
  localparam logic [15:0] THRESH_RST    = 16'h0000;
  localparam int unsigned AID_MAX_KHZ   = 500;
  localparam int unsigned AID_MIN_NS    = 50;
  localparam int unsigned CLK_NS        = 4;
  localparam int unsigned AID_MIN_CYC   = (AID_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned BRAM_WORDS    = 16;
  localparam int unsigned BRAM_AW       = 4;
  localparam logic [1:0]  ROUTE_OFF     = 2'h0;
  localparam logic [1:0]  ROUTE_TXD     = 2'h1;
  localparam logic [1:0]  ROUTE_EVENT   = 2'h2;
  typedef enum logic [1:0] {
    RIO_PWR_RUN   = 2'b00,
    RIO_PWR_IDLE  = 2'b01,
    RIO_PWR_OFF   = 2'b10
  } rio_pwr_t;
endpackage

/* src/rio_ram_if.sv */
// link between the pin block and its backup ram
`timescale 1ns/100ps
interface rio_ram_if;
  logic                 we;
  logic [3:0]           addr;
  logic [31:0]          wdata;
  logic [31:0]          rdata;
  modport ctl (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface

/* src/rio_backup_ram.sv */
// backup ram kept on its own reset so a hardware reset leaves it intact
`timescale 1ns/100ps
module rio_backup_ram (
  input  wire logic core_clk,
  input  wire logic bkp_rst_b,
  rio_ram_if.mem    ram
);
  logic [31:0] mem_q [rio_pkg::BRAM_WORDS];
  genvar gi;
  generate
    for (gi = 0; gi < rio_pkg::BRAM_WORDS; gi++)
    begin : g_word
      always_ff @(posedge core_clk or negedge bkp_rst_b)
      begin
        if (!bkp_rst_b)
          mem_q[gi] <= 32'h0;
        else if (ram.we && ram.addr == 4'(gi))
          mem_q[gi] <= ram.wdata; // R5
      end
    end
  endgenerate
  assign ram.rdata = mem_q[ram.addr];
endmodule

/* src/rio_pin_ctrl.sv */
// receiver misc pin control: pending flag, event input, strap, strobes, amp enable
`timescale 1ns/100ps
module rio_pin_ctrl (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        bkp_rst_b,
  input  wire logic        port_sel_strap_in,
  input  wire logic        pend_en,
  input  wire logic        pend_pol,
  input  wire logic [1:0]  pend_route,
  input  wire logic [15:0] pend_thresh,
  input  wire logic [15:0] tx_byte_count,
  input  wire logic        uart_tx_data,
  input  wire logic        ext_event_in,
  input  wire logic        event_en,
  input  wire logic        event_wake_en,
  input  wire logic        event_pwr_ctl_en,
  input  wire logic        event_time_aid_en,
  input  wire logic        event_freq_aid_en,
  input  wire logic        psm_en,
  input  wire logic        psm_active_phase,
  input  wire logic        strobe_cfg_we,
  input  wire logic [31:0] strobe_period,
  input  wire logic [31:0] strobe_width,
  input  wire logic        strobe2_en,
  input  wire logic        service_boot_in,
  input  wire logic        two_wire_sda_in,
  input  wire logic        two_wire_scl_in,
  input  wire logic        bram_we,
  input  wire logic [3:0]  bram_addr,
  input  wire logic [31:0] bram_wdata,
  output logic [31:0]      bram_rdata,
  output logic             txd_out,
  output logic             ext_event_out,
  output logic             ext_event_oe,
  output logic             uart_sel,
  output logic             two_wire_sel,
  output logic             spi_sel,
  output logic             spi_cs_b,
  output logic             spi_clk,
  output logic             two_wire_sda,
  output logic             two_wire_scl,
  output logic             wake_req,
  output logic             rx_off,
  output logic [1:0]       pwr_state,
  output logic [31:0]      rtc_time,
  output logic [31:0]      freq_aid_count,
  output logic             time_strobe,
  output logic             second_time_strobe,
  output logic             second_time_strobe_oe,
  output logic             front_amp_on
);
  rio_ram_if ram_bus ();
  logic             pend_q;
  logic             strap_q;
  logic             boot_done_q;
  logic             ev_q;
  logic             ev_rise;
  logic             ev_in_use;
  logic [31:0]      per_q;
  logic [31:0]      wid_q;
  logic [31:0]      tcnt_q;
  logic [31:0]      rtc_q;
  logic [31:0]      fcnt_q;
  logic [15:0]      sub_q;
  rio_pkg::rio_pwr_t pwr_q;
  rio_pkg::rio_pwr_t pwr_d;

  // pending level with polarity; inactive level is the inverse of active
  function automatic logic drive_pol(input logic act, input logic pol);
    drive_pol = pol ? act : ~act;
  endfunction

  rio_backup_ram u_bram (
    .core_clk  (core_clk),
    .bkp_rst_b (bkp_rst_b),
    .ram       (ram_bus)
  );
  assign ram_bus.we    = bram_we;
  assign ram_bus.addr  = bram_addr;
  assign ram_bus.wdata = bram_wdata;

  // rst_b is only ever sampled, never driven
  always_ff @(posedge core_clk or negedge rst_b) // R4
  begin
    if (!rst_b)
      bram_rdata <= 32'h0;
    else
      bram_rdata <= ram_bus.rdata;
  end

  // pending flag follows count against threshold both ways
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      pend_q <= 1'b0; // R3
    else
      pend_q <= pend_en && (tx_byte_count >= pend_thresh) && (tx_byte_count != 16'h0); // R1 R17
  end

  // event pin is free for output only when no input function uses it
  assign ev_in_use = event_en | event_wake_en | event_pwr_ctl_en
                   | event_time_aid_en | event_freq_aid_en;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      txd_out       <= 1'b1;
      ext_event_out <= 1'b1;
      ext_event_oe  <= 1'b0;
    end
    else
    begin
      if (pend_route == rio_pkg::ROUTE_TXD && pend_en) // R2
        txd_out <= drive_pol(pend_q, pend_pol); // R1
      else
        txd_out <= uart_tx_data;
      ext_event_oe  <= (pend_route == rio_pkg::ROUTE_EVENT) && pend_en && !ev_in_use; // R2
      ext_event_out <= drive_pol(pend_q, pend_pol);
    end
  end

  // strap caught at reset release; a floating pin reads high through the pull-up
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      strap_q     <= 1'b1; // R15
      boot_done_q <= 1'b0;
    end
    else if (!boot_done_q)
    begin
      strap_q     <= port_sel_strap_in; // R11
      boot_done_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      uart_sel     <= 1'b0;
      two_wire_sel <= 1'b0;
      spi_sel      <= 1'b0;
      spi_cs_b     <= 1'b1;
      spi_clk      <= 1'b1;
      two_wire_sda <= 1'b1;
      two_wire_scl <= 1'b1;
    end
    else
    begin
      uart_sel     <= boot_done_q && strap_q; // R11
      two_wire_sel <= boot_done_q && strap_q;
      spi_sel      <= boot_done_q && !strap_q; // R11
      spi_cs_b     <= strap_q ? 1'b1 : two_wire_sda_in; // R16
      spi_clk      <= strap_q ? 1'b1 : two_wire_scl_in; // R16
      two_wire_sda <= strap_q ? two_wire_sda_in : 1'b1;
      two_wire_scl <= strap_q ? two_wire_scl_in : 1'b1;
    end
  end

  // event input edge detect, disabled functions see nothing
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      ev_q <= 1'b1;
    else
      ev_q <= ext_event_in;
  end
  assign ev_rise = ext_event_in & ~ev_q;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      wake_req <= 1'b0; // R6
    else
      wake_req <= event_wake_en && psm_en && (pwr_q == rio_pkg::RIO_PWR_IDLE) && ev_rise; // R6
  end

  // power state: event level overrides cycling, or forces off outside power save
  always_comb
  begin
    pwr_d = pwr_q;
    case (pwr_q)
      rio_pkg::RIO_PWR_RUN,
      rio_pkg::RIO_PWR_IDLE,
      rio_pkg::RIO_PWR_OFF:
      begin
        if (psm_en && event_pwr_ctl_en)
          pwr_d = ext_event_in ? rio_pkg::RIO_PWR_RUN : rio_pkg::RIO_PWR_IDLE; // R7
        else if (psm_en)
          pwr_d = (psm_active_phase || wake_req) ? rio_pkg::RIO_PWR_RUN
                                                 : rio_pkg::RIO_PWR_IDLE;
        else if (event_pwr_ctl_en && !ext_event_in)
          pwr_d = rio_pkg::RIO_PWR_OFF; // R8
        else
          pwr_d = rio_pkg::RIO_PWR_RUN;
      end
      default: pwr_d = rio_pkg::RIO_PWR_RUN;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      pwr_q <= rio_pkg::RIO_PWR_RUN;
    else
      pwr_q <= pwr_d;
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pwr_state    <= 2'b00;
      rx_off       <= 1'b0;
      front_amp_on <= 1'b1;
    end
    else
    begin
      pwr_state    <= pwr_d;
      rx_off       <= (pwr_d == rio_pkg::RIO_PWR_OFF); // R8
      front_amp_on <= (pwr_d == rio_pkg::RIO_PWR_RUN); // R14
    end
  end

  // rtc: cleared by hardware reset, realigned on an aiding pulse
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rtc_q <= 32'h0; // R5
      sub_q <= 16'h0;
    end
    else if (event_time_aid_en && ev_rise)
    begin
      rtc_q <= rtc_q + 32'h1; // R9
      sub_q <= 16'h0;
    end
    else if (tcnt_q == per_q - 32'h1)
    begin
      rtc_q <= rtc_q + 32'h1;
      sub_q <= 16'h0;
    end
    else
      sub_q <= sub_q + 16'h1;
  end
  assign rtc_time = rtc_q;

  // frequency aiding counts rising edges; a 50 ns phase is 13 cycles so edges are resolvable
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      fcnt_q <= 32'h0;
    else if (event_freq_aid_en && ev_rise)
      fcnt_q <= fcnt_q + 32'h1; // R10
  end
  assign freq_aid_count = fcnt_q;

  // strobe period and width, one per second out of reset
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      per_q <= rio_pkg::STROBE_CYC_RST; // R12
      wid_q <= rio_pkg::STROBE_WID_RST;
    end
    else if (strobe_cfg_we && strobe_period != 32'h0)
    begin
      per_q <= strobe_period; // R12
      wid_q <= strobe_width;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      tcnt_q <= 32'h0;
    else if ((event_time_aid_en && ev_rise) || tcnt_q >= per_q - 32'h1)
      tcnt_q <= 32'h0; // R9
    else
      tcnt_q <= tcnt_q + 32'h1;
  end

  // second strobe sits high while disabled and is not driven until boot is done
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      time_strobe           <= 1'b0;
      second_time_strobe    <= 1'b1;
      second_time_strobe_oe <= 1'b0;
    end
    else
    begin
      time_strobe           <= (tcnt_q < wid_q);
      second_time_strobe    <= strobe2_en ? (tcnt_q < wid_q) : 1'b1;
      second_time_strobe_oe <= strobe2_en && boot_done_q && service_boot_in; // R13
    end
  end
endmodule

/* tb/rio_host_model.sv */
// far-side model driving the event pin and the service boot pin
`timescale 1ns/100ps
module rio_host_model (
  input  wire logic core_clk,
  input  wire logic rst_b,
  input  wire logic aid_on,
  input  wire logic ev_lvl,
  output logic      ext_event_in,
  output logic      service_boot_in
);
  // 250 cycles a phase: 500 kHz at most, each phase far above 50 ns
  localparam int HALF = 250;
  int   cnt;
  logic aid_q;
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
    begin
      cnt   <= 0;
      aid_q <= 1'h1;
    end
    else if (cnt == HALF - 1)
    begin
      cnt   <= 0;
      aid_q <= ~aid_q;
    end
    else
      cnt <= cnt + 1;
  assign ext_event_in    = aid_on ? aid_q : ev_lvl;
  // never pulled low, so reset and start-up are safe
  assign service_boot_in = 1'h1;
endmodule

/* tb/rio_pin_ctrl_assertions.sv */
// port assertions for the receiver pin control block
`timescale 1ns/100ps
module rio_pin_ctrl_assertions (
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire logic        pend_en,
  input wire logic        pend_pol,
  input wire logic        uart_tx_data,
  input wire logic        txd_out,
  input wire logic        event_en,
  input wire logic        event_wake_en,
  input wire logic        event_pwr_ctl_en,
  input wire logic        event_time_aid_en,
  input wire logic        event_freq_aid_en,
  input wire logic        ext_event_oe,
  input wire logic        ext_event_in,
  input wire logic        psm_en,
  input wire logic        psm_active_phase,
  input wire logic        front_amp_on,
  input wire logic        spi_sel,
  input wire logic        uart_sel,
  input wire logic        two_wire_sel,
  input wire logic        spi_clk,
  input wire logic        two_wire_scl_in,
  input wire logic        wake_req,
  input wire logic [1:0]  pend_route,
  input wire logic [1:0]  pwr_state,
  input wire logic [15:0] pend_thresh,
  input wire logic [15:0] tx_byte_count
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  logic any_ev;
  logic hit;
  logic on_txd;
  assign any_ev = event_en | event_wake_en | event_pwr_ctl_en | event_time_aid_en
                  | event_freq_aid_en;
  assign hit = tx_byte_count != 16'h0 && tx_byte_count >= pend_thresh;
  assign on_txd = pend_en && pend_route == rio_pkg::ROUTE_TXD;
  a_pend_flag_on:
    assert property ((on_txd && hit && $stable(pend_pol))[*3] |-> txd_out == pend_pol)
      else $error("flag not active");
  a_pend_flag_off:
    assert property ((on_txd && !hit && $stable(pend_pol))[*3] |-> txd_out == !pend_pol)
      else $error("flag not dropped");
  a_txd_pass:
    assert property ((!on_txd && $stable(uart_tx_data))[*3] |-> txd_out == uart_tx_data)
      else $error("txd not uart data");
  a_event_oe_off:
    assert property (any_ev |=> !ext_event_oe) else $error("event pin driven");
  a_sel_excl:
    assert property (spi_sel |-> !uart_sel && !two_wire_sel) else $error("ports overlap");
  a_spi_clk_map:
    assert property (spi_sel ##1 spi_sel |-> spi_clk == $past(two_wire_scl_in))
      else $error("spi clock map");
  a_amp_phase:
    assert property ((psm_en && !event_pwr_ctl_en && !wake_req
      && $stable(psm_active_phase))[*4]
      |-> front_amp_on == psm_active_phase) else $error("amp phase");
  // a wake-up is an active phase of its own, so the amplifier must come on
  a_wake_run:
    assert property (wake_req |=> front_amp_on) else $error("wake left amp off");
  a_pwr_ctl:
    assert property ((psm_en && event_pwr_ctl_en && $stable(ext_event_in))[*4]
      |-> pwr_state == (ext_event_in ? rio_pkg::RIO_PWR_RUN : rio_pkg::RIO_PWR_IDLE))
      else $error("power control");
  a_force_off:
    assert property ((!psm_en && event_pwr_ctl_en && !ext_event_in)[*4]
      |-> pwr_state == rio_pkg::RIO_PWR_OFF) else $error("not forced off");
  a_wake_pulse:
    assert property (wake_req |=> !wake_req) else $error("wake not a pulse");
  cover property (on_txd && hit);
  cover property (spi_sel);
  cover property (wake_req);
endmodule
bind rio_pin_ctrl rio_pin_ctrl_assertions u_rio_pin_ctrl_assertions (
  .core_clk, .rst_b, .pend_en, .pend_pol, .uart_tx_data, .txd_out, .event_en,
  .event_wake_en, .event_pwr_ctl_en, .event_time_aid_en, .event_freq_aid_en,
  .ext_event_oe, .ext_event_in, .psm_en, .psm_active_phase, .front_amp_on, .spi_sel,
  .uart_sel, .two_wire_sel, .spi_clk, .two_wire_scl_in, .wake_req, .pend_route,
  .pwr_state, .pend_thresh, .tx_byte_count
);

/* tb/tb.sv */
// self-checking bench for the receiver pin control block
`timescale 1ns/100ps
module tb;
  logic core_clk = '0, rst_b = '0, bkp_rst_b = '0, port_sel_strap_in = '1, pend_en = '0;
  logic pend_pol = '0, uart_tx_data = '1, event_en = '0, event_wake_en = '0, psm_en = '0;
  logic event_pwr_ctl_en = '0, event_time_aid_en = '0, event_freq_aid_en = '0, ev_lvl = '1;
  logic psm_active_phase = '0, strobe_cfg_we = '0, strobe2_en = '0, two_wire_sda_in = '1;
  logic two_wire_scl_in = '1, bram_we = '0, aid_on = '0;
  logic [1:0] pend_route = '0;
  logic [3:0] bram_addr = '0;
  logic [15:0] pend_thresh = '0, tx_byte_count = '0;
  logic [31:0] strobe_period = '0, strobe_width = '0, bram_wdata = '0, lf = 32'h7dd0;
  logic ext_event_in, service_boot_in, txd_out, ext_event_out, ext_event_oe, uart_sel;
  logic two_wire_sel, spi_sel, spi_cs_b, spi_clk, two_wire_sda, two_wire_scl, wake_req;
  logic rx_off, time_strobe, second_time_strobe, second_time_strobe_oe, front_amp_on;
  logic [1:0] pwr_state;
  logic [31:0] bram_rdata, rtc_time, freq_aid_count;
  int fails = 0, check_count = 0;
  logic [31:0] ram_q[$];
  rio_pin_ctrl u_rio_pin_ctrl (.*);
  rio_host_model u_rio_host_model (.*);
  always #2 core_clk = ~core_clk;
  task automatic go();
    @(posedge core_clk);
  endtask
  // results are read at the falling edge, away from the update edge
  task automatic look(int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (fails == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic do_reset(logic s);
    go();
    rst_b <= '0;
    port_sel_strap_in <= s;
    look(4);
    go();
    rst_b <= '1;
    look(4);
  endtask
  task automatic to_rise(output int n);
    n = 0;
    while (time_strobe !== 1'h0 && n < 400)
    begin
      look(1);
      n++;
    end
    // n keeps counting so a call from one rise spans a full period
    while (time_strobe !== 1'h1 && n < 400)
    begin
      look(1);
      n++;
    end
    if (n >= 400)
    begin
      fails++;
      close_out();
    end
  endtask
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int flag_exp(int c, int t, int p);
    return (c != 0 && c >= t) ? p : 1 - p;
  endfunction
  initial
  begin
    int c;
    logic [31:0] r0;
    logic b;
    look(1);
    chk(txd_out, 1);
    chk(ext_event_oe, 0);
    look(3);
    go();
    rst_b <= '1;
    bkp_rst_b <= '1;
    uart_tx_data <= '0;
    look(4);
    chk({uart_sel, two_wire_sel, spi_sel}, 3'h6);
    chk(txd_out, 0);
    go();
    pend_en <= '1;
    repeat (24)
    begin
      lf = lfsr(lf);
      pend_thresh <= 16'(lf[3:0]);
      tx_byte_count <= 16'(lf[7:4]);
      pend_pol <= lf[8];
      pend_route <= lf[10:9];
      look(4);
      c = flag_exp(lf[7:4], lf[3:0], lf[8]);
      chk(ext_event_out, c);
      chk(txd_out, (lf[10:9] == 2'h1) ? c : 0);
      chk(ext_event_oe, lf[10:9] == 2'h2);
      go();
    end
    event_en <= '1;
    event_time_aid_en <= '1;
    ev_lvl <= '0;
    look(2);
    go();
    ev_lvl <= '1;
    look(3);
    chk(rtc_time, 1);
    chk(ext_event_oe, 0);
    go();
    event_time_aid_en <= '0;
    bram_we <= '1;
    bram_addr <= 4'h5;
    bram_wdata <= lf;
    ram_q.push_back(lf);
    go();
    bram_we <= '0;
    do_reset(1'h0);
    chk(rtc_time, 0);
    chk(bram_rdata, ram_q.pop_front());
    chk({uart_sel, two_wire_sel, spi_sel}, 3'h1);
    go();
    two_wire_sda_in <= '0;
    two_wire_scl_in <= '0;
    event_pwr_ctl_en <= '1;
    psm_en <= '1;
    look(5);
    chk({spi_cs_b, spi_clk}, 2'h0);
    chk({two_wire_sda, two_wire_scl}, 2'h3);
    chk({pwr_state, front_amp_on}, 3'h1);
    go();
    ev_lvl <= '0;
    look(5);
    chk({pwr_state, front_amp_on}, 3'h2);
    go();
    psm_en <= '0;
    look(5);
    chk(pwr_state, 2);
    chk(rx_off, 1);
    for (int p = 0; p < 2; p++)
    begin
      go();
      event_pwr_ctl_en <= '0;
      psm_en <= '1;
      psm_active_phase <= 1'(p);
      look(5);
      chk(front_amp_on, p);
    end
    go();
    event_wake_en <= '1;
    psm_active_phase <= '0;
    look(3);
    go();
    ev_lvl <= '1;
    c = 0;
    repeat (8)
    begin
      look(1);
      c += int'(wake_req);
    end
    chk(c, 1);
    go();
    event_wake_en <= '0;
    psm_en <= '0;
    strobe_period <= 32'h14;
    strobe_width <= 32'h5;
    strobe_cfg_we <= '1;
    strobe2_en <= '1;
    go();
    strobe_cfg_we <= '0;
    to_rise(c);
    to_rise(c);
    chk(c, 20);
    look(6);
    chk({time_strobe, second_time_strobe, second_time_strobe_oe}, 3'h1);
    go();
    strobe_period <= '0;
    strobe_cfg_we <= '1;
    go();
    strobe_cfg_we <= '0;
    to_rise(c);
    to_rise(c);
    chk(c, 20);
    go();
    event_time_aid_en <= '1;
    ev_lvl <= '0;
    strobe_period <= 32'hffff;
    strobe_cfg_we <= '1;
    go();
    strobe_cfg_we <= '0;
    look(4);
    r0 = rtc_time;
    go();
    ev_lvl <= '1;
    look(4);
    chk(rtc_time, r0 + 32'h1);
    chk(time_strobe, 1);
    go();
    event_time_aid_en <= '0;
    event_freq_aid_en <= '1;
    aid_on <= '1;
    look(2);
    // counter snapshot one look after the first sample keeps both tallies aligned
    b = ext_event_in;
    c = 0;
    for (int i = 0; i < 2200; i++)
    begin
      look(1);
      if (i == 0)
        r0 = freq_aid_count;
      if (ext_event_in && !b)
        c++;
      b = ext_event_in;
    end
    look(1);
    chk(freq_aid_count - r0, c);
    chk(c >= 4, 1);
    chk(freq_aid_count != 32'h0, 1);
    close_out();
  end
endmodule
